// ---- dv/fiber_far_side_model.sv ----
// Stand-in for the autonegotiation engine, the FIFOs and the detect pin.
// Assumes the bench calls its tasks from the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module fiber_far_side_model (
    input wire logic clk_i,
    output var fiber_np_pkg::partner_page_s partner_page_o,
    output var fiber_np_pkg::fiber_events_s events_o,
    output var logic page_sent_o,
    output var logic signal_detect_o
);
    import fiber_np_pkg::*;

    // ****************************************
    // Quiet state at time zero
    // ****************************************
    initial begin
        partner_page_o = '0;
        events_o = '0;
        page_sent_o = 1'b0;
        signal_detect_o = 1'b0;
    end

    // One-cycle page strobe; the word is not held after it
    task automatic send_page(input logic [15:0] w);
        @(posedge clk_i);
        partner_page_o <= '{valid: 1'b1, word: w};
        @(posedge clk_i);
        partner_page_o <= '{valid: 1'b0, word: ~w};
    endtask : send_page

    // One-cycle strobe on one event source
    task automatic raise(input int i);
        @(posedge clk_i);
        events_o[i] <= 1'b1;
        @(posedge clk_i);
        events_o <= '0;
    endtask : raise

    // Local page went out on the line
    task automatic send_local();
        @(posedge clk_i);
        page_sent_o <= 1'b1;
        @(posedge clk_i);
        page_sent_o <= 1'b0;
    endtask : send_local

    // Level on the external detect pin
    task automatic set_detect(input logic v);
        @(posedge clk_i);
        signal_detect_o <= v;
    endtask : set_detect
endmodule : fiber_far_side_model
`default_nettype wire

// ---- dv/fiber_next_page_and_irq_regs_tb.sv ----
// Self-checking bench for the fiber next-page and interrupt register bank.
// Assumes a one-cycle Wishbone answer and the far-side model beside it.
`timescale 1ns/1ps
`default_nettype none
module fiber_next_page_and_irq_regs_tb;
    import fiber_np_pkg::*;

    // ****************************************
    // Addresses, stimulus and instances
    // ****************************************
    localparam logic [13:0] A_LOC = {LOCAL_NP_IDX, 2'b00};
    localparam logic [13:0] A_PRT = {PARTNER_NP_IDX, 2'b00};
    localparam logic [13:0] A_CTL = {FIBER_CTRL_IDX, 2'b00};
    localparam logic [13:0] A_EN = {IRQ_EN_IDX, 2'b00};
    localparam logic [13:0] A_STS = {IRQ_STS_IDX, 2'b00};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [13:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic [15:0] local_page_o;
    logic ack_o, irq_o, dq, sent, detect;
    partner_page_s page;
    fiber_events_s events;
    int mismatches = 0;
    int n_compared = 0;

    fiber_next_page_and_irq_regs uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .partner_page_i(page),
        .local_page_sent_i(sent), .events_i(events), .signal_detect_i(detect),
        .local_page_o(local_page_o), .detect_qualified_o(dq), .irq_o(irq_o)
    );
    fiber_far_side_model fp (
        .clk_i(clk_i), .partner_page_o(page), .events_o(events),
        .page_sent_o(sent), .signal_detect_o(detect)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    // Classic cycle held until ack is sampled high
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask : bus

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        bus(1'b1, a, d, s, q);
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, 4'hf, q);
        chk(q, e);
    endtask : rd

    // Registered flags lag their cause; two edges is a safe margin
    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask : settle

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [15:0] words [2];
        words = '{16'hb9a5, 16'h125a};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_LOC, 32'h0000_0001);
        chk({16'h0, local_page_o}, 32'h0000_0001);
        rd(A_PRT, 32'h0);
        rd(A_CTL, 32'h0);
        rd(A_EN, 32'h0000_03ff);
        rd(A_STS, 32'h0);
        rd(14'h0000, 32'h0);
        // Local code, output word and toggle flips
        wr(A_LOC, 32'h0000_07ff, 4'h3);
        rd(A_LOC, 32'h0000_07ff);
        settle();
        chk({16'h0, local_page_o}, 32'h0000_07ff);
        fp.send_local();
        rd(A_LOC, 32'h0000_0fff);
        chk({16'h0, local_page_o}, 32'h0000_0fff);
        fp.send_local();
        rd(A_LOC, 32'h0000_07ff);
        // Partner pages land whole and flag a next page
        foreach (words[k]) begin
            fp.send_page(words[k]);
            rd(A_PRT, {16'h0, words[k]});
            rd(A_STS, 32'h2);
        end
        wr(A_PRT, 32'h0000_ffff, 4'hf);
        rd(A_PRT, 32'h0000_125a);
        // Every source, fiber and serial FIFO strobes alike
        for (int i = 0; i < 14; i++) begin
            fp.raise(i);
            settle();
            chk({31'h0, irq_o}, 32'h1);
            rd(A_STS, 32'h1 << (i < 9 ? i : i - 4));
            rd(A_STS, 32'h0);
        end
        // Masked source stays pending but silent
        wr(A_EN, 32'h0000_0010, 4'hf);
        fp.raise(0);
        settle();
        chk({31'h0, irq_o}, 32'h0);
        wr(A_EN, 32'h0000_0001, 4'h3);
        settle();
        chk({31'h0, irq_o}, 32'h1);
        rd(A_STS, 32'h1);
        settle();
        chk({31'h0, irq_o}, 32'h0);
        wr(A_EN, 32'h0000_03ff, 4'h1);
        rd(A_EN, 32'h0000_0001);
        wr(A_EN, 32'h0000_03ff, 4'h3);
        rd(A_EN, 32'h0000_03ff);
        // Event on the clearing edge survives the read; the read word misses it
        fork
            rd(A_STS, 32'h0);
            begin
                @(posedge clk_i);
                fp.raise(4);
            end
        join
        rd(A_STS, 32'h10);
        rd(A_STS, 32'h0);
        // Detect pin used, then overridden
        fp.set_detect(1'b0);
        settle();
        chk({31'h0, dq}, 32'h0);
        fp.set_detect(1'b1);
        settle();
        chk({31'h0, dq}, 32'h1);
        wr(A_CTL, 32'h0000_0200, 4'h3);
        fp.set_detect(1'b0);
        settle();
        chk({31'h0, dq}, 32'h1);
        rd(A_CTL, 32'h0000_0200);
        conclude();
    end
endmodule : fiber_next_page_and_irq_regs_tb
`default_nettype wire

// ---- verilog/fiber_next_page_and_irq_regs.sv ----
// Fiber next-page registers, signal-detect select and interrupt bank.
// Assumes a classic Wishbone master with one outstanding cycle; events are strobes.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fiber_next_page_and_irq_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [fiber_np_pkg::ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Autonegotiation side
    input wire fiber_np_pkg::partner_page_s partner_page_i,
    input wire logic local_page_sent_i,                  // Local page transmitted
    input wire fiber_np_pkg::fiber_events_s events_i,
    input wire logic signal_detect_i,                    // External detect pin
    output logic [15:0] local_page_o,                    // Outgoing next page
    output logic detect_qualified_o,                     // Detect used for link
    output logic irq_o
);
    import fiber_np_pkg::*;

    // ****************************************
    // State record
    // ****************************************
    typedef struct packed {
        bus_state_e bus;
        logic ack;
        logic [31:0] rdata;
        logic local_page_toggle;
        logic [CODE_W-1:0] local_page_code;
        logic [15:0] partner_word;
        logic ignore_detect_input;
        logic [NSRC-1:0] irq_enable;
        logic detect_q;
        logic [15:0] local_page;
    } regs_s;

    regs_s st_r;
    regs_s st_nxt;

    logic [NSRC-1:0] pending;   // Sticky status from the latch
    logic [NSRC-1:0] ev_vec;    // Gathered event strobes
    logic sts_read;             // Status read being acked
    logic irq_int;              // Latch interrupt

    // Request decode helpers
    logic req;
    logic [ADDR_W-1:0] a_word;
    assign req = cyc_i && stb_i;
    assign a_word = {adr_i[ADDR_W-1:2], 2'b00};

    // ****************************************
    // Event gathering
    // ****************************************
    always_comb begin
        ev_vec = '0;
        // RQ12 far-end fault
        ev_vec[SRC_FAR_FAULT] = events_i.far_end_fault;
        // RQ13 RQ10 FIFO events from both paths
        ev_vec[SRC_TX_FULL] = events_i.fiber_tx_full | events_i.serial_tx_full;
        ev_vec[SRC_TX_EMPTY] = events_i.fiber_tx_empty | events_i.serial_tx_empty;
        ev_vec[SRC_RX_FULL] = events_i.fiber_rx_full | events_i.serial_rx_full;
        ev_vec[SRC_RX_EMPTY] = events_i.fiber_rx_empty | events_i.serial_rx_empty;
        // RQ14 link change
        ev_vec[SRC_LINK] = events_i.link_change;
        // RQ15 partner remote fault
        ev_vec[SRC_PARTNER_FAULT] = events_i.partner_fault;
        // RQ16 resolution failure
        ev_vec[SRC_RESOLVE] = events_i.resolve_fail;
        // RQ17 page received events
        ev_vec[SRC_NEXT_PAGE] = events_i.next_page | partner_page_i.valid;
        ev_vec[SRC_BASE_PAGE] = events_i.base_page;
    end

    // Status clear only at the acked read of the status word
    assign sts_read = (st_r.bus == BUS_ACK) && !we_i && (a_word == byte_addr(IRQ_STS_IDX));

    // Sticky status and interrupt
    irq_event_latch #(
        .N(NSRC)
    ) u_latch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(ev_vec),
        .enable_i(st_r.irq_enable),
        .read_clear_i(sts_read),
        .pending_o(pending),
        .irq_o(irq_int)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        case (st_r.bus)
            // Take a request, prepare read data
            BUS_IDLE: begin
                if (req) begin
                    st_nxt.bus = BUS_ACK;
                    st_nxt.ack = 1'b1;
                    if (a_word == byte_addr(LOCAL_NP_IDX)) begin
                        // RQ1 RQ2 local word
                        st_nxt.rdata = {20'h0, st_r.local_page_toggle, st_r.local_page_code};
                    end else if (a_word == byte_addr(PARTNER_NP_IDX)) begin
                        // RQ3 RQ4 RQ5 RQ6 RQ7 partner word
                        st_nxt.rdata = {16'h0, st_r.partner_word};
                    end else if (a_word == byte_addr(FIBER_CTRL_IDX)) begin
                        st_nxt.rdata = 32'h0;
                        st_nxt.rdata[IGNORE_SD_BIT] = st_r.ignore_detect_input;
                    end else if (a_word == byte_addr(IRQ_EN_IDX)) begin
                        st_nxt.rdata = {22'h0, st_r.irq_enable};
                    end else if (a_word == byte_addr(IRQ_STS_IDX)) begin
                        // Pending plus events landing now
                        st_nxt.rdata = {22'h0, pending | ev_vec};
                    end else begin
                        // Unmapped reads return zero, writes dropped
                        st_nxt.rdata = 32'h0;
                    end
                end
            end
            // Ack cycle: commit writes, then release
            BUS_ACK: begin
                st_nxt.bus = BUS_IDLE;
                if (we_i && sel_i[1] && sel_i[0]) begin
                    if (a_word == byte_addr(LOCAL_NP_IDX)) begin
                        // RQ2 writable code
                        st_nxt.local_page_code = dat_i[CODE_W-1:0];
                    end else if (a_word == byte_addr(FIBER_CTRL_IDX)) begin
                        st_nxt.ignore_detect_input = dat_i[IGNORE_SD_BIT];
                    end else if (a_word == byte_addr(IRQ_EN_IDX)) begin
                        // RQ9 enables writable
                        st_nxt.irq_enable = dat_i[NSRC-1:0];
                    end
                end
            end
            default: begin
                st_nxt.bus = BUS_IDLE;
            end
        endcase
        // RQ1 toggle flips after each page sent
        if (local_page_sent_i) begin
            st_nxt.local_page_toggle = ~st_r.local_page_toggle;
        end
        // RQ7 capture received partner page
        if (partner_page_i.valid) begin
            st_nxt.partner_word = partner_page_i.word;
        end
        // RQ8 detect pin qualifies link unless ignored
        st_nxt.detect_q = st_r.ignore_detect_input | signal_detect_i;
        // Outgoing page carries the code and toggle
        st_nxt.local_page = {4'h0, st_nxt.local_page_toggle, st_nxt.local_page_code};
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.bus <= BUS_IDLE;
            st_r.ack <= 1'b0;
            st_r.rdata <= 32'h0;
            st_r.local_page_toggle <= 1'b0;
            st_r.local_page_code <= LOCAL_CODE_RST;
            st_r.partner_word <= PARTNER_RST;
            st_r.ignore_detect_input <= 1'b0;
            // RQ9 all enabled after reset
            st_r.irq_enable <= IRQ_EN_RST;
            st_r.detect_q <= 1'b0;
            st_r.local_page <= {5'h00, LOCAL_CODE_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign dat_o = st_r.rdata;
    assign ack_o = st_r.ack;
    assign local_page_o = st_r.local_page;
    assign detect_qualified_o = st_r.detect_q;
    assign irq_o = irq_int;

    // ****************************************
    // Assertions
    // ****************************************
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) // Wishbone ack, decided for this implementation
        else $error("ack held more than one cycle");
    a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_o && st_r.bus == BUS_IDLE) |=> ack_o)
        else $error("ack not given next cycle");
    a_partner_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        partner_page_i.valid |=> st_r.partner_word == $past(partner_page_i.word)) // RQ7
        else $error("partner page not captured");
    a_toggle_flip: assert property (@(posedge clk_i) disable iff (rst_i)
        local_page_sent_i |=> local_page_o[TOGGLE_BIT] != $past(st_r.local_page_toggle)) // RQ1
        else $error("local toggle did not flip");
    a_detect_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.ignore_detect_input ##1 st_r.ignore_detect_input |-> detect_qualified_o) // RQ8
        else $error("detect not ignored");
    a_fifo_both_paths: assert property (@(posedge clk_i) disable iff (rst_i)
        events_i.serial_tx_full |=> pending[SRC_TX_FULL]) // RQ10
        else $error("serial FIFO event missed");
    a_far_fault_set: assert property (@(posedge clk_i) disable iff (rst_i)
        events_i.far_end_fault |=> pending[SRC_FAR_FAULT]) // RQ12
        else $error("far-end fault not latched");
    a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        (events_i.link_change && st_r.irq_enable[SRC_LINK]) |=> irq_o) // RQ18
        else $error("enabled event raised no interrupt");

    c_status_read: cover property (@(posedge clk_i) sts_read && pending != '0);
    c_page_rx: cover property (@(posedge clk_i) partner_page_i.valid ##2 ack_o);
    c_irq_rise: cover property (@(posedge clk_i) !irq_o ##1 irq_o);
    c_enable_write: cover property (@(posedge clk_i)
        st_r.bus == BUS_ACK && we_i && a_word == byte_addr(IRQ_EN_IDX));

endmodule : fiber_next_page_and_irq_regs
`default_nettype wire

// ---- verilog/fiber_np_pkg.sv ----
// Constants, types and register map of the fiber next-page and interrupt registers.
// Assumes a classic Wishbone slave with 32-bit data and a single 200 MHz clock.
//
// Behaviour
// RQ1 - Local toggle bit 11, read-only, resets 0
// RQ2 - Local eleven-bit code writable, resets to 1
// RQ3 - Partner bit 15: more pages follow
// RQ4 - Partner bit 13: message or unformatted page
// RQ5 - Partner bit 12: partner can comply
// RQ6 - Partner bit 11: partner toggle bit
// RQ7 - Partner code bits 10-0, register resets zero
// RQ8 - Control bit 9 ignores signal detect input
// RQ9 - Ten interrupt enables, all set at reset
// RQ10 - FIFO enables cover fiber and serial paths
// RQ11 - Status bits pending, cleared by reading
// RQ12 - Bit 9 set on far-end fault
// RQ13 - Bits 8..5 on FIFO full/empty events
// RQ14 - Bit 4 set on link status change
// RQ15 - Bit 3 set on partner remote fault
// RQ16 - Bit 2 set on resolution failure
// RQ17 - Bit 1 next page, bit 0 base page
// RQ18 - Interrupt high for enabled pending bit
// RQ19 - Event during read stays pending
package fiber_np_pkg;

    // ****************************************
    // Register indices and byte addresses
    // ****************************************
    localparam logic [11:0] LOCAL_NP_IDX = 12'hc07;      // Local next-page word
    localparam logic [11:0] PARTNER_NP_IDX = 12'hc08;    // Partner next-page word
    localparam logic [11:0] FIBER_CTRL_IDX = 12'hc10;    // Fiber control zero
    localparam logic [11:0] IRQ_EN_IDX = 12'hc18;        // Interrupt enable
    localparam logic [11:0] IRQ_STS_IDX = 12'hc19;       // Interrupt status
    localparam int ADDR_W = 14;                         // Byte address width

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int TOGGLE_BIT = 11;
    localparam int MORE_BIT = 15;
    localparam int KIND_BIT = 13;
    localparam int COMPLY_BIT = 12;
    localparam int IGNORE_SD_BIT = 9;
    localparam int CODE_W = 11;
    localparam int NSRC = 10;
    localparam logic [10:0] LOCAL_CODE_RST = 11'h001;
    localparam logic [15:0] PARTNER_RST = 16'h0000;
    localparam logic [9:0] IRQ_EN_RST = 10'h3ff;
    localparam logic [9:0] IRQ_STS_RST = 10'h000;

    // Interrupt source positions
    localparam int SRC_FAR_FAULT = 9;
    localparam int SRC_TX_FULL = 8;
    localparam int SRC_TX_EMPTY = 7;
    localparam int SRC_RX_FULL = 6;
    localparam int SRC_RX_EMPTY = 5;
    localparam int SRC_LINK = 4;
    localparam int SRC_PARTNER_FAULT = 3;
    localparam int SRC_RESOLVE = 2;
    localparam int SRC_NEXT_PAGE = 1;
    localparam int SRC_BASE_PAGE = 0;

    // Bus access phase
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;

    // Received next page from the autonegotiation engine
    typedef struct packed {
        logic valid;              // One-cycle strobe
        logic [15:0] word;        // Page as received
    } partner_page_s;

    // Fiber datapath event strobes, one cycle each
    typedef struct packed {
        logic far_end_fault;
        logic fiber_tx_full;
        logic fiber_tx_empty;
        logic fiber_rx_full;
        logic fiber_rx_empty;
        logic serial_tx_full;
        logic serial_tx_empty;
        logic serial_rx_full;
        logic serial_rx_empty;
        logic link_change;
        logic partner_fault;
        logic resolve_fail;
        logic next_page;
        logic base_page;
    } fiber_events_s;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

endpackage : fiber_np_pkg

// ---- verilog/irq_event_latch.sv ----
// Sticky interrupt status with clear-on-read and an enable-gated output.
// Assumes event strobes and the read-clear strobe are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module irq_event_latch #(
    parameter int N = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] event_i,       // Source strobes
    input wire logic [N-1:0] enable_i,      // Per-source enables
    input wire logic read_clear_i,          // Status read completes
    output logic [N-1:0] pending_o,         // Sticky status
    output logic irq_o                      // Registered interrupt
);
    import fiber_np_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [N-1:0] pending;
        logic irq;
    } latch_s;

    latch_s st_r;
    latch_s st_nxt;

    // Next state
    always_comb begin
        st_nxt = st_r;
        // RQ11 clear on read; RQ19 set wins
        st_nxt.pending = (read_clear_i ? '0 : st_r.pending) | event_i;
        // RQ18 enable-gated output
        st_nxt.irq = |(st_nxt.pending & enable_i);
    end

    // Register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pending_o = st_r.pending;
    assign irq_o = st_r.irq;

    // Event in read cycle survives
    a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (read_clear_i && event_i != '0) |=> ((pending_o & $past(event_i)) == $past(event_i))) // RQ19
        else $error("event lost during read clear");
    // Read with no event clears
    a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (read_clear_i && event_i == '0) |=> pending_o == '0) // RQ11
        else $error("status not cleared by read");
    // Output follows gated status
    a_irq_gating: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(pending_o & enable_i) || $changed(enable_i)) // RQ18
        else $error("interrupt output mismatch");

endmodule : irq_event_latch
`default_nettype wire
